// *** rsc_defines.svh ***
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH
// Register byte offsets
`define RSC_OFF_CAUSE 8'h00
`define RSC_OFF_SYSC3 8'h04
`define RSC_OFF_KEY 8'h08
`define RSC_OFF_CTRL 8'h0c
// Cause register field positions
`define RSC_BIT_VDET 0
`define RSC_BIT_WDT 1
`define RSC_BIT_CLK 2
`define RSC_BIT_TRIM 3
`define RSC_BIT_FLASH 4
`define RSC_BIT_TRMF 5
`define RSC_BIT_CLRQ 6
// System control three field
`define RSC_BIT_PINDIS 0
// Key codes
`define RSC_KEY_CLEAR 8'h71
`define RSC_KEY_PIN 8'hb2
// Timing
`define RSC_CLK_MHZ 50
`define RSC_PULSE_NS 5000
`define RSC_PULSE_CYC ((`RSC_PULSE_NS * `RSC_CLK_MHZ + 999) / 1000)
`define RSC_WARMUP_CYC 1024
// AXI responses
`define RSC_RESP_OK 2'h0
`define RSC_RESP_SLVERR 2'h2
`endif

// *** rsc_pkg.sv ***
package rsc_pkg;
  typedef enum logic [1:0] {
    RSC_RESET,
    RSC_WARMUP,
    RSC_RUN
  } rsc_state_t;
endpackage : rsc_pkg

// *** rsc_sync.sv ***
`timescale 1ns/1ps
module rsc_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] async_in,
  input wire logic [W-1:0] reset_val,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end
  // Reset value is a tied constant from the parent
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= reset_val;
      sync_q <= reset_val;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  assign sync_out = sync_q;
endmodule : rsc_sync

// *** rsc_top.sv ***
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "rsc_defines.svh"
// Operation
// - Power-on reset OR pin reset holds reset
// - Warm-up starts at later source release
// - Core held halted until warm-up completes
// - Pin low five microseconds causes reset
// - Voltage detect raises internal reset
// - Watchdog overflow raises internal reset
// - Clock deadlock setting raises internal reset
// - Corrupted latched trim raises internal reset
// - Trim data loaded during every warm-up
// - Abnormal loaded trim sets fault flag
// - Flash standby access raises internal reset
// - Cause register shows internal reset source
// - Cause cleared by pin, POR or clear key
// - Clear request plus key 0x71 clears
// - Clear request bit self-clears afterwards
// - Disable bit plus key 0xB2 frees pin
// - Cleared bit plus key 0xB2 restores
// - Shared pin defaults to reset function
// - Reset during warm-up restarts counter
module rsc_top
  import rsc_pkg::*;
#(
  parameter int WARMUP_CYC = `RSC_WARMUP_CYC,
  parameter int TRIM_W = 8
) (
  // Clock and bus reset
  input wire logic aclk,
  input wire logic aresetn,
  // Reset sources
  input wire logic por_n,
  input wire logic reset_pin_n,
  input wire logic vdet_req,
  input wire logic wdt_ovf,
  input wire logic clk_deadlock,
  input wire logic flash_standby_access,
  // Trim store
  input wire logic [TRIM_W-1:0] trim_store_data,
  input wire logic trim_store_ok,
  // Outputs
  output logic core_reset_n,
  output logic warmup_active,
  output logic [TRIM_W-1:0] trim_latched,
  output logic pin_is_port,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam logic [15:0] PULSE_CYC = 16'(`RSC_PULSE_CYC);
  localparam logic [31:0] WARM_LAST = 32'(WARMUP_CYC - 1);

  logic [6:0] src_sync;
  logic por_s, pin_s, vdet_s, wdt_s, clkd_s, flash_s, tok_s;
  rsc_sync #(.W(7)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({por_n, reset_pin_n, vdet_req, wdt_ovf, clk_deadlock,
               flash_standby_access, trim_store_ok}),
    .reset_val(7'h60),
    .sync_out(src_sync)
  );
  assign {por_s, pin_s, vdet_s, wdt_s, clkd_s, flash_s, tok_s} = src_sync;

  // State
  rsc_state_t state_q, state_d;
  logic [31:0] warm_q, warm_d;
  logic [15:0] low_q, low_d;
  logic [TRIM_W-1:0] trim_q, trim_d, trim_chk_q, trim_chk_d;
  logic [4:0] cause_q, cause_d;
  logic trmf_q, trmf_d, clrq_q, clrq_d, dis_q, dis_d, port_q, port_d;
  logic cold_q, cold_d, rstn_q, rstn_d, wact_q, wact_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic awr_q, awr_d, wr_q, wr_d, bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
  logic [7:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d;
  logic [3:0] ws_q, ws_d;
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic pin_rst, cold_rst, int_rst, trim_bad, wr_go, rd_go, trm_load;
  logic [4:0] int_src;
  always_comb begin
    // Pulse filter: pin low counted only while it acts as reset
    pin_rst = !port_q && (low_q >= PULSE_CYC);
    cold_rst = !por_s || pin_rst;
    trim_bad = (state_q == RSC_RUN) && (trim_q != trim_chk_q);
    int_src = 5'h00;
    int_src[`RSC_BIT_VDET] = vdet_s;
    int_src[`RSC_BIT_WDT] = wdt_s;
    int_src[`RSC_BIT_CLK] = clkd_s;
    int_src[`RSC_BIT_TRIM] = trim_bad;
    int_src[`RSC_BIT_FLASH] = flash_s && (state_q == RSC_RUN);
    int_rst = |int_src;
    wr_go = aw_have_q && w_have_q && !bv_q;
    rd_go = s_axi_arvalid && arr_q;
  end
  always_comb begin
    trm_load = 1'b0;
    state_d = state_q;
    warm_d = warm_q;
    low_d = (!pin_s && !port_q) ? ((low_q == 16'hffff) ? low_q : low_q + 16'h1)
                                : 16'h0;
    trim_d = trim_q;
    trim_chk_d = trim_chk_q;
    cause_d = cause_q;
    trmf_d = trmf_q;
    clrq_d = clrq_q;
    dis_d = dis_q;
    port_d = port_q;
    cold_d = cold_q;
    awr_d = awr_q;
    wr_d = wr_q;
    bv_d = bv_q;
    bresp_d = bresp_q;
    arr_d = arr_q;
    rv_d = rv_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    awa_d = awa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    // Reset sequencing
    if (cold_rst || int_rst) begin
      state_d = RSC_RESET;
      warm_d = 32'h0;
      if (cold_rst) begin
        cold_d = 1'b1;
      end
    end else begin
      unique case (state_q)
        RSC_RESET: begin
          state_d = RSC_WARMUP;
          warm_d = 32'h0;
        end
        RSC_WARMUP: begin
          trim_d = trim_store_data;
          trim_chk_d = trim_store_data;
          if (warm_q == WARM_LAST) begin
            state_d = RSC_RUN;
            trmf_d = !tok_s;
            trm_load = 1'b1;
            cold_d = 1'b0;
          end else begin
            warm_d = warm_q + 32'h1;
          end
        end
        RSC_RUN: begin
        end
      endcase
    end
    // Cause bits: cleared by cold reset or clear key, sticky otherwise
    if (cold_rst) begin
      cause_d = 5'h00;
      trmf_d = 1'b0;
      clrq_d = 1'b0;
      dis_d = 1'b0;
      port_d = 1'b0;
    end else if (int_rst) begin
      cause_d = cause_q | int_src;
    end
    // AXI write channel capture
    if (s_axi_awvalid && awr_q) begin
      awa_d = s_axi_awaddr;
      aw_have_d = 1'b1;
      awr_d = 1'b0;
    end
    if (s_axi_wvalid && wr_q) begin
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
      w_have_d = 1'b1;
      wr_d = 1'b0;
    end
    if (wr_go) begin
      bv_d = 1'b1;
      bresp_d = `RSC_RESP_OK;
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      unique case (awa_q)
        `RSC_OFF_CAUSE: begin
          if (ws_q[0] && !cold_rst) begin
            clrq_d = wd_q[`RSC_BIT_CLRQ];
          end
        end
        `RSC_OFF_SYSC3: begin
          if (ws_q[0] && !cold_rst) begin
            dis_d = wd_q[`RSC_BIT_PINDIS];
          end
        end
        `RSC_OFF_KEY: begin
          // Only the matching code applies a pending change
          if (ws_q[0] && !cold_rst) begin
            if (wd_q[7:0] == `RSC_KEY_CLEAR && clrq_q) begin
              // Events in this cycle still land
              cause_d = int_rst ? int_src : 5'h00;
              trmf_d = trm_load && trmf_d;
              clrq_d = 1'b0;
            end else if (wd_q[7:0] == `RSC_KEY_PIN) begin
              port_d = dis_q;
            end
          end
        end
        `RSC_OFF_CTRL: begin
          bresp_d = `RSC_RESP_OK;
        end
        default: begin
          bresp_d = `RSC_RESP_SLVERR;
        end
      endcase
    end
    if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
      awr_d = 1'b1;
      wr_d = 1'b1;
    end
    // AXI read
    if (rd_go) begin
      arr_d = 1'b0;
      rv_d = 1'b1;
      rresp_d = `RSC_RESP_OK;
      unique case (s_axi_araddr)
        `RSC_OFF_CAUSE: rdata_d = {25'h0, clrq_q, trmf_q, cause_q};
        `RSC_OFF_SYSC3: rdata_d = {31'h0, dis_q};
        `RSC_OFF_KEY: rdata_d = 32'h0;
        `RSC_OFF_CTRL: rdata_d = {29'h0, port_q, rstn_q,
                                  state_q == RSC_WARMUP};
        default: begin
          rdata_d = 32'h0;
          rresp_d = `RSC_RESP_SLVERR;
        end
      endcase
    end
    if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
      arr_d = 1'b1;
    end
    rstn_d = (state_d == RSC_RUN);
    wact_d = (state_d == RSC_WARMUP);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= RSC_RESET;
      warm_q <= 32'h0;
      low_q <= 16'h0;
      trim_q <= '0;
      trim_chk_q <= '0;
      cause_q <= 5'h00;
      trmf_q <= 1'b0;
      clrq_q <= 1'b0;
      dis_q <= 1'b0;
      port_q <= 1'b0;
      cold_q <= 1'b1;
      rstn_q <= 1'b0;
      wact_q <= 1'b0;
      awr_q <= 1'b1;
      wr_q <= 1'b1;
      bv_q <= 1'b0;
      bresp_q <= 2'h0;
      arr_q <= 1'b1;
      rv_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h0;
      awa_q <= 8'h00;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
    end else begin
      state_q <= state_d;
      warm_q <= warm_d;
      low_q <= low_d;
      trim_q <= trim_d;
      trim_chk_q <= trim_chk_d;
      cause_q <= cause_d;
      trmf_q <= trmf_d;
      clrq_q <= clrq_d;
      dis_q <= dis_d;
      port_q <= port_d;
      cold_q <= cold_d;
      rstn_q <= rstn_d;
      wact_q <= wact_d;
      awr_q <= awr_d;
      wr_q <= wr_d;
      bv_q <= bv_d;
      bresp_q <= bresp_d;
      arr_q <= arr_d;
      rv_q <= rv_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
    end
  end

  always_comb begin
    core_reset_n = rstn_q;
    warmup_active = wact_q;
    trim_latched = trim_q;
    pin_is_port = port_q;
    s_axi_awready = awr_q;
    s_axi_wready = wr_q;
    s_axi_bvalid = bv_q;
    s_axi_bresp = bresp_q;
    s_axi_arready = arr_q;
    s_axi_rvalid = rv_q;
    s_axi_rresp = rresp_q;
    s_axi_rdata = rdata_q;
  end
endmodule : rsc_top

// *** rsc_top_asserts.sv ***
`timescale 1ns/1ps
module rsc_top_asserts #(
  parameter int WARMUP_CYC = 1024,
  parameter int TRIM_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Reset sources
  input wire logic por_n,
  input wire logic vdet_req,
  input wire logic wdt_ovf,
  input wire logic clk_deadlock,
  input wire logic flash_standby_access,
  // Core side
  input wire logic core_reset_n,
  input wire logic warmup_active,
  input wire logic [TRIM_W-1:0] trim_latched,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  por_hold_a: assert property (!por_n |-> ##[1:6] !core_reset_n)
    else $error("core runs during power-on reset");
  src_reset_a: assert property ((vdet_req || wdt_ovf || clk_deadlock ||
    flash_standby_access) && core_reset_n |-> ##[1:6] !core_reset_n)
    else $error("internal source did not reset core");
  core_halt_a: assert property (warmup_active |-> !core_reset_n)
    else $error("core released during warm-up");
  warm_len_a: assert property ($rose(core_reset_n) |->
    $past(warmup_active, WARMUP_CYC)) else $error("warm-up too short");
  trim_hold_a: assert property (core_reset_n && $past(core_reset_n)
    |-> $stable(trim_latched)) else $error("trim changed while running");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  wr_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
endmodule : rsc_top_asserts
bind rsc_top rsc_top_asserts #(.WARMUP_CYC(WARMUP_CYC), .TRIM_W(TRIM_W))
  u_rsc_top_asserts (.*);

// *** rsc_board.sv ***
`timescale 1ns/1ps
module rsc_board (
  // Clock
  input wire logic aclk,
  // Reset pin
  output logic reset_pin_n
);
  // Low from power-up until supply and oscillation settle
  initial reset_pin_n = 1'b0;
  // Pin rests high between pulses, so function switches see a high
  task automatic hold_low(input int n);
    @(posedge aclk);
    reset_pin_n <= 1'b0;
    repeat (n) @(posedge aclk);
    reset_pin_n <= 1'b1;
  endtask : hold_low
endmodule : rsc_board

// *** testbench.sv ***
`timescale 1ns/1ps
`include "rsc_defines.svh"
module testbench;
  import rsc_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, por_n = 1'b0, trim_store_ok = 1'b1;
  logic [3:0] src = 4'h0, s_axi_wstrb = 4'hf;
  logic [7:0] trim_store_data = 8'ha5, trim_latched;
  logic vdet_req, wdt_ovf, clk_deadlock, flash_standby_access;
  logic core_reset_n, warmup_active, pin_is_port, reset_pin_n;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  localparam int WARM = 8;
  int err_total = 0;
  int compares = 0;
  assign {flash_standby_access, clk_deadlock, wdt_ovf, vdet_req} = src;
  always #10 aclk = ~aclk;
  rsc_top #(.WARMUP_CYC(WARM)) u_rsc_top (.*);
  rsc_board u_rsc_board (.*);
  task automatic print_verdict;
    if (err_total == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string s, input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic guard(input int n);
    if (n >= 2000) begin
      err_total++;
      print_verdict;
    end
  endtask : guard
  task automatic wcore(input logic v);
    int n;
    n = 0;
    while (core_reset_n !== v && n < 2000) begin
      @(posedge aclk);
      n++;
    end
    guard(n);
  endtask : wcore
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 2000);
    guard(n);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, s_axi_bresp},
      (a <= `RSC_OFF_CTRL && a[1:0] == 2'h0) ? {30'h0, `RSC_RESP_OK}
                                             : {30'h0, `RSC_RESP_SLVERR});
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] re);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 2000);
    guard(n);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, e);
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, re});
  endtask : rdc
  // Pulses internal sources, then waits out reset and warm-up
  task automatic kick(input logic [3:0] v);
    @(posedge aclk);
    src <= v;
    @(posedge aclk);
    src <= 4'h0;
    wcore(1'b0);
    wcore(1'b1);
  endtask : kick
  task automatic t_src;
    logic [31:0] e;
    int b[4];
    b = '{`RSC_BIT_VDET, `RSC_BIT_WDT, `RSC_BIT_CLK, `RSC_BIT_FLASH};
    e = 32'h0;
    for (int i = 0; i < 4; i++) begin
      kick(4'h1 << i);
      e[b[i]] = 1'b1;
      rdc(`RSC_OFF_CAUSE, e, `RSC_RESP_OK);
    end
  endtask : t_src
  task automatic t_clr;
    wr(`RSC_OFF_CAUSE, 32'h40);
    wr(`RSC_OFF_KEY, 32'h55);
    rdc(`RSC_OFF_CAUSE, 32'h57, `RSC_RESP_OK);
    wr(`RSC_OFF_KEY, {24'h0, `RSC_KEY_CLEAR});
    rdc(`RSC_OFF_CAUSE, 32'h0, `RSC_RESP_OK);
  endtask : t_clr
  task automatic t_trim;
    trim_store_ok <= 1'b0;
    trim_store_data <= 8'h3c;
    kick(4'h2);
    chk("trim", {24'h0, trim_latched}, 32'h3c);
    rdc(`RSC_OFF_CAUSE, 32'h22, `RSC_RESP_OK);
    trim_store_ok <= 1'b1;
    // Software answers the fault with a clock reset to reload trim
    kick(4'h4);
    rdc(`RSC_OFF_CAUSE, 32'h06, `RSC_RESP_OK);
  endtask : t_trim
  task automatic t_pin;
    wr(`RSC_OFF_SYSC3, 32'h1);
    wr(`RSC_OFF_KEY, {24'h0, `RSC_KEY_PIN});
    chk("port", {31'h0, pin_is_port}, 32'h1);
    u_rsc_board.hold_low(300);
    chk("core", {31'h0, core_reset_n}, 32'h1);
    wr(`RSC_OFF_SYSC3, 32'h0);
    wr(`RSC_OFF_KEY, {24'h0, `RSC_KEY_PIN});
    chk("port", {31'h0, pin_is_port}, 32'h0);
  endtask : t_pin
  task automatic t_pulse;
    u_rsc_board.hold_low(260);
    chk("core", {31'h0, core_reset_n}, 32'h0);
    wcore(1'b1);
    rdc(`RSC_OFF_CAUSE, 32'h0, `RSC_RESP_OK);
  endtask : t_pulse
  // Second source lands mid warm-up; the count must start again
  task automatic t_restart;
    int n, c;
    @(posedge aclk);
    src <= 4'h1;
    @(posedge aclk);
    src <= 4'h0;
    n = 0;
    while (warmup_active !== 1'b1 && n < 2000) begin
      @(posedge aclk);
      n++;
    end
    guard(n);
    repeat (2) @(posedge aclk);
    src <= 4'h2;
    @(posedge aclk);
    src <= 4'h0;
    n = 0;
    c = 0;
    while (core_reset_n !== 1'b1 && n < 2000) begin
      @(posedge aclk);
      n++;
      if (warmup_active === 1'b1) c++;
      else if (core_reset_n !== 1'b1) c = 0;
    end
    guard(n);
    chk("warmup", c, WARM);
    rdc(`RSC_OFF_CAUSE, 32'h3, `RSC_RESP_OK);
  endtask : t_restart
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    por_n <= 1'b1;
    u_rsc_board.hold_low(260);
    chk("core", {31'h0, core_reset_n}, 32'h0);
    wcore(1'b1);
    chk("trim", {24'h0, trim_latched}, 32'ha5);
    rdc(`RSC_OFF_CTRL, 32'h2, `RSC_RESP_OK);
    rdc(8'h10, 32'h0, `RSC_RESP_SLVERR);
    wr(8'h10, 32'h0);
    t_src;
    t_clr;
    t_trim;
    t_pin;
    t_pulse;
    t_restart;
    print_verdict;
  end
endmodule : testbench
